/* File: pim_pkg.sv */
// Constants, register map and types of the transceiver interrupt management block
package pim_pkg;

  // Core clock rate
  localparam int unsigned CLK_KHZ = 40000;

  // Management register addresses
  localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
  localparam logic [4:0] REG_AN_EXPANSION = 5'h06;
  localparam logic [4:0] REG_MODE_CTRL = 5'h11;
  localparam logic [4:0] REG_WAKE_CTRL = 5'h1b;
  localparam logic [4:0] REG_IRQ_FLAGS = 5'h1d;
  localparam logic [4:0] REG_IRQ_MASK = 5'h1e;

  // Read answer and reset values
  localparam logic [15:0] RD_UNMAPPED = 16'hffff;
  localparam logic [15:0] FLAGS_RST = 16'h0080;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] SRC_RST = 16'h0080;
  localparam logic [7:0] WAKE_RST = 8'h00;
  localparam logic ALT_MODE_RST = 1'b0;

  // Flag and mode bit positions
  localparam int unsigned BIT_LINK_UP = 9;
  localparam int unsigned BIT_WAKE = 8;
  localparam int unsigned BIT_ENERGY = 7;
  localparam int unsigned BIT_AN_DONE = 6;
  localparam int unsigned BIT_RFAULT = 5;
  localparam int unsigned BIT_LINK_DOWN = 4;
  localparam int unsigned BIT_LP_ACK = 3;
  localparam int unsigned BIT_PD_FAULT = 2;
  localparam int unsigned BIT_PAGE_RX = 1;
  localparam int unsigned MODE_ALT_BIT = 6;
  localparam int unsigned MODE_ENERGY_BIT = 1;

  // Flag groups
  localparam logic [15:0] FLAG_BITS = 16'h03fe;
  localparam logic [15:0] CLR_ON_FALL = 16'h03ee;
  localparam logic [15:0] CLR_ON_REG1 = 16'h0030;
  localparam logic [15:0] CLR_ON_REG6 = 16'h0006;

  // Management frame
  localparam logic [5:0] PREAMBLE_ONES = 6'd32;
  localparam logic [3:0] HDR_LAST = 4'd11;
  localparam logic [3:0] DATA_LAST = 4'd15;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;

  // Late energy pulse timing
  localparam int unsigned LATE_DELAY_MS = 1000;
  localparam int unsigned LATE_PULSE_MS = 256;
  localparam int unsigned LATE_DELAY_CYC = LATE_DELAY_MS * CLK_KHZ;
  localparam int unsigned LATE_PULSE_CYC = LATE_PULSE_MS * CLK_KHZ;

  typedef enum logic [2:0] {S_PRE, S_START, S_HDR, S_TA, S_RDATA, S_WDATA} pim_state_t;
  typedef enum logic [1:0] {L_IDLE, L_ARMED, L_WAIT, L_PULSE} pim_late_t;

endpackage

/* File: pim_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pim_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // Pin side
  input wire logic i_pin,
  // Core side
  output logic o_level
);

  logic meta_ff;
  logic sync2_ff;
  logic sync3_ff;
  logic level_ff;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta_ff <= RESET_VAL;
      sync2_ff <= RESET_VAL;
      sync3_ff <= RESET_VAL;
    end else if (i_clk_en) begin
      meta_ff <= i_pin;
      sync2_ff <= meta_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // A change counts only once two late stages agree
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      level_ff <= RESET_VAL;
    end else if (i_clk_en && (sync2_ff == sync3_ff)) begin
      level_ff <= sync3_ff;
    end
  end

  assign o_level = level_ff;

endmodule

/* File: pim_top.sv */
// Transceiver interrupt management with serial management link slave
`timescale 1ns/10ps
module pim_top
  import pim_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h00,
  parameter int unsigned LATE_DELAY = LATE_DELAY_CYC,
  parameter int unsigned LATE_PULSE = LATE_PULSE_CYC
) (
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // Management link pins
  input wire logic i_mdc,
  input wire logic i_mdio,
  output logic o_mdio,
  output logic o_mdio_oe_n,
  // Interrupt sources from transceiver logic
  input wire logic i_internal_link_up,
  input wire logic i_energy_present,
  input wire logic i_an_complete,
  input wire logic i_remote_fault,
  input wire logic i_link_status,
  input wire logic i_lp_ack,
  input wire logic i_pd_fault,
  input wire logic i_page_rx,
  input wire logic i_an_restart,
  input wire logic [3:0] i_wake_hit,
  // To system interrupt controller
  output logic o_irq
);

  localparam int unsigned CNT_W = 26;

  if (LATE_DELAY < 2 || LATE_PULSE < 2 || LATE_DELAY >= (1 << CNT_W) ||
      LATE_PULSE >= (1 << CNT_W)) begin : g_bad_late
    $error("pim_top: late energy counts out of range");
  end

  pim_state_t state_ff;
  pim_late_t late_ff;
  logic [5:0] ones_ff;
  logic [3:0] cnt_ff;
  logic [4:0] regad_ff;
  logic [7:0] wake_ff;
  logic [CNT_W-1:0] late_cnt_ff;
  logic [11:0] hdr_ff, hdr_next;
  logic [15:0] wdata_ff, wdata_next, rd_shift_ff, flags_ff, nxt_flags, mask_ff;
  logic [15:0] src_q_ff, src, rise, fall, clr;
  logic mdc_lvl, mdio_lvl, mdc_q_ff, mdc_rise, is_read_ff, mdio_ff, mdio_oe_n_ff;
  logic rd_take, wr_take, alt_mode_ff, irq_ff;

  function automatic logic [15:0] reg_read(input logic [4:0] addr, input logic [15:0] flags,
                                           input logic [15:0] mask, input logic alt,
                                           input logic energy, input logic [7:0] wake);
    logic [15:0] v;
    case (addr)
      REG_IRQ_FLAGS: v = flags & FLAG_BITS;
      REG_IRQ_MASK: v = mask & FLAG_BITS;
      REG_MODE_CTRL: begin
        v = 16'h0000;
        v[MODE_ALT_BIT] = alt;
        v[MODE_ENERGY_BIT] = energy;
      end
      REG_WAKE_CTRL: v = {8'h00, wake};
      default: v = RD_UNMAPPED;
    endcase
    return v;
  endfunction

  // Link pins pass the synchroniser; the core clock finds the link clock edges
  pim_sync #(.RESET_VAL(1'b0)) u_sync_mdc (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
    .i_pin(i_mdc), .o_level(mdc_lvl)
  );

  pim_sync #(.RESET_VAL(1'b1)) u_sync_mdio (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en),
    .i_pin(i_mdio), .o_level(mdio_lvl)
  );

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mdc_q_ff <= 1'b0;
    end else if (i_clk_en) begin
      mdc_q_ff <= mdc_lvl;
    end
  end

  assign mdc_rise = mdc_lvl & ~mdc_q_ff;
  assign hdr_next = {hdr_ff[10:0], mdio_lvl};
  assign wdata_next = {wdata_ff[14:0], mdio_lvl};
  assign rd_take = mdc_rise && (state_ff == S_HDR) && (cnt_ff == HDR_LAST) &&
                   (hdr_next[11:10] == OP_READ) && (hdr_next[9:5] == PHY_ADDR);
  assign wr_take = mdc_rise && (state_ff == S_WDATA) && (cnt_ff == DATA_LAST);

  // Frame decoder: preamble, start, header, turnaround, data
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= S_PRE;
      ones_ff <= 6'd0;
      cnt_ff <= 4'd0;
      hdr_ff <= 12'h000;
      regad_ff <= 5'h00;
      wdata_ff <= 16'h0000;
      is_read_ff <= 1'b0;
    end else if (i_clk_en && mdc_rise) begin
      case (state_ff)
        S_PRE: begin
          if (mdio_lvl) begin
            if (ones_ff != PREAMBLE_ONES) begin
              ones_ff <= ones_ff + 6'd1;
            end
          end else begin
            ones_ff <= 6'd0;
            if (ones_ff == PREAMBLE_ONES) begin
              state_ff <= S_START;
            end
          end
        end
        S_START: begin
          cnt_ff <= 4'd0;
          state_ff <= mdio_lvl ? S_HDR : S_PRE;
        end
        S_HDR: begin
          hdr_ff <= hdr_next;
          cnt_ff <= cnt_ff + 4'd1;
          if (cnt_ff == HDR_LAST) begin
            cnt_ff <= 4'd0;
            regad_ff <= hdr_next[4:0];
            // Frames for another address are dropped; preamble resyncs
            if (hdr_next[9:5] == PHY_ADDR &&
                (hdr_next[11:10] == OP_READ || hdr_next[11:10] == OP_WRITE)) begin
              is_read_ff <= (hdr_next[11:10] == OP_READ);
              state_ff <= S_TA;
            end else begin
              state_ff <= S_PRE;
            end
          end
        end
        S_TA: begin
          cnt_ff <= cnt_ff + 4'd1;
          if (cnt_ff != 4'd0) begin
            cnt_ff <= 4'd0;
            state_ff <= is_read_ff ? S_RDATA : S_WDATA;
          end
        end
        S_RDATA, S_WDATA: begin
          wdata_ff <= wdata_next;
          cnt_ff <= cnt_ff + 4'd1;
          if (cnt_ff == DATA_LAST) begin
            cnt_ff <= 4'd0;
            state_ff <= S_PRE;
          end
        end
        default: state_ff <= S_PRE;
      endcase
    end
  end

  // Read data drive; changes follow the rising link clock edge
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_shift_ff <= 16'h0000;
      mdio_ff <= 1'b1;
      mdio_oe_n_ff <= 1'b1;
    end else if (i_clk_en) begin
      if (rd_take) begin
        rd_shift_ff <= reg_read(hdr_next[4:0], flags_ff, mask_ff, alt_mode_ff,
                                i_energy_present, wake_ff);
      end else if (mdc_rise && state_ff == S_TA && is_read_ff) begin
        if (cnt_ff == 4'd0) begin
          mdio_ff <= 1'b0;
          mdio_oe_n_ff <= 1'b0;
        end else begin
          mdio_ff <= rd_shift_ff[15];
        end
      end else if (mdc_rise && state_ff == S_RDATA) begin
        if (cnt_ff == DATA_LAST) begin
          mdio_ff <= 1'b1;
          mdio_oe_n_ff <= 1'b1;
        end else begin
          mdio_ff <= rd_shift_ff[14];
          rd_shift_ff <= {rd_shift_ff[14:0], 1'b0};
        end
      end
    end
  end

  // Active-high view of each source; link-down is active when status is low
  always_comb begin
    src = 16'h0000;
    src[BIT_LINK_UP] = i_internal_link_up;
    src[BIT_WAKE] = |(wake_ff[7:4] & wake_ff[3:0]);
    src[BIT_ENERGY] = i_energy_present;
    src[BIT_AN_DONE] = i_an_complete;
    src[BIT_RFAULT] = i_remote_fault;
    src[BIT_LINK_DOWN] = ~i_link_status;
    src[BIT_LP_ACK] = i_lp_ack;
    src[BIT_PD_FAULT] = i_pd_fault;
    src[BIT_PAGE_RX] = i_page_rx;
  end

  assign rise = src & ~src_q_ff;
  assign fall = ~src & src_q_ff;

  always_comb begin
    clr = 16'h0000;
    if (!alt_mode_ff) begin
      clr = fall & CLR_ON_FALL;
      if (rd_take && hdr_next[4:0] == REG_IRQ_FLAGS) begin
        clr = clr | FLAG_BITS;
      end
      if (rd_take && hdr_next[4:0] == REG_BASIC_STATUS) begin
        clr = clr | CLR_ON_REG1;
      end
      if ((rd_take && hdr_next[4:0] == REG_AN_EXPANSION) || i_an_restart ||
          rise[BIT_LINK_DOWN]) begin
        clr = clr | CLR_ON_REG6;
      end
    end else if (wr_take && regad_ff == REG_IRQ_FLAGS) begin
      clr = wdata_next & ~src & FLAG_BITS;
    end
    // Set wins over any clear in the same cycle
    nxt_flags = ((flags_ff & ~clr) | (rise & FLAG_BITS)) & FLAG_BITS;
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      flags_ff <= FLAGS_RST;
      src_q_ff <= SRC_RST;
    end else if (i_clk_en) begin
      flags_ff <= nxt_flags;
      src_q_ff <= src;
    end
  end

  // Mask and mode registers written over the link
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mask_ff <= MASK_RST;
      alt_mode_ff <= ALT_MODE_RST;
    end else if (i_clk_en && wr_take) begin
      if (regad_ff == REG_IRQ_MASK) begin
        mask_ff <= wdata_next & FLAG_BITS;
      end
      if (regad_ff == REG_MODE_CTRL) begin
        alt_mode_ff <= wdata_next[MODE_ALT_BIT];
      end
    end
  end

  // Wake status bits set by hardware, write one to clear; set wins
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wake_ff <= WAKE_RST;
    end else if (i_clk_en) begin
      if (wr_take && regad_ff == REG_WAKE_CTRL) begin
        wake_ff <= {(wake_ff[7:4] & ~wdata_next[7:4]) | i_wake_hit, wdata_next[3:0]};
      end else begin
        wake_ff[7:4] <= wake_ff[7:4] | i_wake_hit;
      end
    end
  end

  // Energy flag cleared while energy still present arms a late pulse
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      late_ff <= L_IDLE;
      late_cnt_ff <= '0;
    end else if (i_clk_en) begin
      case (late_ff)
        L_IDLE: begin
          if (mask_ff[BIT_ENERGY] && flags_ff[BIT_ENERGY] && !nxt_flags[BIT_ENERGY] &&
              src[BIT_ENERGY]) begin
            late_ff <= L_ARMED;
          end
        end
        L_ARMED: begin
          if (fall[BIT_ENERGY]) begin
            late_ff <= L_WAIT;
            late_cnt_ff <= CNT_W'(LATE_DELAY - 1);
          end
        end
        L_WAIT: begin
          late_cnt_ff <= late_cnt_ff - 1'b1;
          if (late_cnt_ff == '0) begin
            late_ff <= L_PULSE;
            late_cnt_ff <= CNT_W'(LATE_PULSE - 1);
          end
        end
        L_PULSE: begin
          late_cnt_ff <= late_cnt_ff - 1'b1;
          if (late_cnt_ff == '0) begin
            late_ff <= L_IDLE;
          end
        end
        default: late_ff <= L_IDLE;
      endcase
    end
  end

  // Clearing the energy mask suppresses the late pulse
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_ff <= 1'b0;
    end else if (i_clk_en) begin
      irq_ff <= (|(flags_ff & mask_ff & FLAG_BITS)) ||
                (late_ff == L_PULSE && mask_ff[BIT_ENERGY]);
    end
  end

  assign o_irq = irq_ff;
  assign o_mdio = mdio_ff;
  assign o_mdio_oe_n = mdio_oe_n_ff;

endmodule

/* File: pim_top_props.sv */
// Checker of management link timing and interrupt output causes
`timescale 1ns/10ps
module pim_top_chk #(
  parameter int unsigned LATE_DELAY = 20,
  parameter int unsigned LATE_PULSE = 10
) (
  // Clock, reset, enable
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // Management link pins
  input wire logic i_mdc,
  input wire logic i_mdio,
  input wire logic o_mdio,
  input wire logic o_mdio_oe_n,
  // Interrupt sources
  input wire logic i_internal_link_up,
  input wire logic i_energy_present,
  input wire logic i_an_complete,
  input wire logic i_remote_fault,
  input wire logic i_link_status,
  input wire logic i_lp_ack,
  input wire logic i_pd_fault,
  input wire logic i_page_rx,
  input wire logic i_an_restart,
  input wire logic [3:0] i_wake_hit,
  // Interrupt output
  input wire logic o_irq
);
  logic [31:0] quiet_ff, rise_ff, efall_ff, drv_ff, hi_ff;
  logic [9:0] src;

  assign src = {i_internal_link_up, i_energy_present, i_an_complete, i_remote_fault,
                i_link_status, i_lp_ack, i_pd_fault, i_page_rx, i_an_restart, |i_wake_hit};

  function automatic logic [31:0] sat(input logic [31:0] v);
    return (v == 32'hffffffff) ? v : v + 32'h1;
  endfunction

  // Cycles since any source or link clock change; the late pulse is the only quiet-time change
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      quiet_ff <= 32'hffffffff;
      rise_ff <= 32'hffffffff;
      efall_ff <= 32'hffffffff;
    end else begin
      quiet_ff <= ($changed(src) || $changed(i_mdc)) ? 32'h0 : sat(quiet_ff);
      rise_ff <= $rose(i_mdc) ? 32'h0 : sat(rise_ff);
      efall_ff <= $fell(i_energy_present) ? 32'h0 : sat(efall_ff);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      drv_ff <= 32'h0;
      hi_ff <= 32'h0;
    end else begin
      drv_ff <= o_mdio_oe_n ? 32'h0 : drv_ff + 32'h1;
      hi_ff <= o_irq ? hi_ff + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_drive_on;
    $fell(o_mdio_oe_n) ##0 !o_mdio;
  endsequence

  chk_first_idle: assert property ($rose(i_reset_n) |-> !o_irq && o_mdio_oe_n && o_mdio)
    else $error("outputs not idle after reset");
  chk_release_level: assert property (o_mdio_oe_n |-> o_mdio)
    else $error("released data line not high");
  chk_turn_zero: assert property ($fell(o_mdio_oe_n) |-> s_drive_on ##1 !o_mdio_oe_n[*8])
    else $error("turnaround drive wrong");
  chk_drive_span: assert property ($rose(o_mdio_oe_n) |-> drv_ff >= 133 && drv_ff <= 139)
    else $error("read drive length wrong");
  chk_bit_timing: assert property (!o_mdio_oe_n && $changed(o_mdio) |-> rise_ff <= 8)
    else $error("data bit not launched after clock rise");
  chk_idle_release: assert property (rise_ff >= 16 |-> o_mdio_oe_n)
    else $error("data line driven with clock idle");
  chk_irq_rise_cause: assert property ($rose(o_irq) |-> quiet_ff <= 8 ||
    (efall_ff >= LATE_DELAY && efall_ff <= LATE_DELAY + 4)) else $error("irq rose without cause");
  chk_irq_fall_cause: assert property ($fell(o_irq) |-> quiet_ff <= 8 ||
    (efall_ff >= LATE_DELAY + LATE_PULSE && efall_ff <= LATE_DELAY + LATE_PULSE + 4))
    else $error("irq fell without cause");
  chk_late_length: assert property ($fell(o_irq) && quiet_ff > 8 |->
    hi_ff + 1 >= LATE_PULSE && hi_ff <= LATE_PULSE + 1) else $error("late pulse length wrong");
endmodule

bind pim_top pim_top_chk #(.LATE_DELAY(LATE_DELAY), .LATE_PULSE(LATE_PULSE)) u_pim_top_chk (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_mdc(i_mdc),
  .i_mdio(i_mdio), .o_mdio(o_mdio), .o_mdio_oe_n(o_mdio_oe_n),
  .i_internal_link_up(i_internal_link_up), .i_energy_present(i_energy_present),
  .i_an_complete(i_an_complete), .i_remote_fault(i_remote_fault),
  .i_link_status(i_link_status), .i_lp_ack(i_lp_ack), .i_pd_fault(i_pd_fault),
  .i_page_rx(i_page_rx), .i_an_restart(i_an_restart), .i_wake_hit(i_wake_hit), .o_irq(o_irq));

/* File: pim_mgmt_master.sv */
// Station management master model driving framed reads and writes
`timescale 1ns/10ps
module pim_mgmt_master
  import pim_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  // Clock
  input wire logic i_core_clk,
  // Management wire
  input wire logic i_mdio,
  output logic o_mdc,
  output logic o_mdio,
  output logic o_mdio_en
);
  initial begin
    o_mdc = 1'b0;
    o_mdio = 1'b1;
    o_mdio_en = 1'b0;
  end

  // One 200 ns bit; data changes while the clock is low, sampled at its rise
  task automatic send_bit(input logic d, input logic en, output logic s);
    @(posedge i_core_clk);
    o_mdc <= 1'b0;
    o_mdio <= d;
    o_mdio_en <= en;
    repeat (4) @(posedge i_core_clk);
    o_mdc <= 1'b1;
    s = i_mdio;
    repeat (3) @(posedge i_core_clk);
  endtask

  task automatic frame(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rv);
    logic [31:0] hdr;
    logic s;
    hdr = {2'b01, rd ? OP_READ : OP_WRITE, PHY_ADDR, ra, rd ? 2'b11 : 2'b10, wd};
    for (int i = 0; i < 32; i++) send_bit(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      send_bit(hdr[i], !(rd && i < 18), s);
      if (i < 16) rv[i] = s;
    end
    // Clock parks low between frames; spare cycles let the slave release first
    @(posedge i_core_clk);
    o_mdc <= 1'b0;
    o_mdio_en <= 1'b0;
    repeat (4) @(posedge i_core_clk);
  endtask
endmodule

/* File: test_phy_irq_mgmt_control.sv */
// Self-checking bench of the interrupt management block
`timescale 1ns/10ps
module test_phy_irq_mgmt_control
  import pim_pkg::*;
;
  localparam int unsigned L_DELAY = 20;
  localparam int unsigned L_PULSE = 10;
  logic clk, rst_n, clk_en, mdc, m_out, m_en, dev_mdio, dev_oe_n, irq, mdio_w;
  logic link_up, energy, an, rf, lstat, lp, pd, page, restart;
  logic [3:0] wake_hit;
  logic [15:0] v;
  int failures, total_checks, cyc;

  // Pull-up wins when nobody drives the wire
  assign mdio_w = !dev_oe_n ? dev_mdio : (m_en ? m_out : 1'b1);

  pim_top #(.LATE_DELAY(L_DELAY), .LATE_PULSE(L_PULSE)) u_pim_top (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_clk_en(clk_en), .i_mdc(mdc), .i_mdio(mdio_w),
    .o_mdio(dev_mdio), .o_mdio_oe_n(dev_oe_n), .i_internal_link_up(link_up),
    .i_energy_present(energy), .i_an_complete(an), .i_remote_fault(rf),
    .i_link_status(lstat), .i_lp_ack(lp), .i_pd_fault(pd), .i_page_rx(page),
    .i_an_restart(restart), .i_wake_hit(wake_hit), .o_irq(irq));
  pim_mgmt_master u_pim_mgmt_master (
    .i_core_clk(clk), .i_mdio(mdio_w), .o_mdc(mdc), .o_mdio(m_out), .o_mdio_en(m_en));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic final_report();
    if (failures == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      final_report();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chk_irq(input logic e);
    check("irq", {15'h0, irq}, {15'h0, e});
  endtask

  task automatic rd(input logic [4:0] ra, output logic [15:0] d);
    u_pim_mgmt_master.frame(1'b1, ra, 16'h0, d);
  endtask

  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] t;
    u_pim_mgmt_master.frame(1'b0, ra, wd, t);
  endtask

  // Drives a source to its active or inactive level by flag position
  task automatic set_src(input int idx, input logic a);
    @(posedge clk);
    case (idx)
      9: link_up <= a;
      7: energy <= a;
      6: an <= a;
      5: rf <= a;
      4: lstat <= !a;
      3: lp <= a;
      2: pd <= a;
      default: page <= a;
    endcase
    repeat (3) @(posedge clk);
  endtask

  task automatic pulse(input logic [3:0] h, input logic rs);
    @(posedge clk);
    wake_hit <= h;
    restart <= rs;
    @(posedge clk);
    wake_hit <= 4'h0;
    restart <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset();
    rd(REG_IRQ_FLAGS, v);
    check("flags", v, 16'h0080);
    rd(REG_IRQ_FLAGS, v);
    check("flags", v, 16'h0000);
    rd(REG_IRQ_MASK, v);
    check("mask", v, 16'h0000);
    rd(REG_MODE_CTRL, v);
    check("mode", v, 16'h0002);
    rd(5'h05, v);
    check("unmapped", v, 16'hffff);
    set_src(7, 1'b0);
  endtask

  task automatic t_primary();
    int ids[8] = '{9, 7, 6, 5, 4, 3, 2, 1};
    wr(REG_IRQ_MASK, 16'h03fe);
    rd(REG_IRQ_MASK, v);
    check("mask", v, 16'h03fe);
    foreach (ids[k]) begin
      set_src(ids[k], 1'b1);
      chk_irq(1'b1);
      set_src(ids[k], 1'b0);
      if (ids[k] == 4) begin
        chk_irq(1'b1);
        rd(REG_BASIC_STATUS, v);
      end
      chk_irq(1'b0);
    end
  endtask

  task automatic t_restart();
    set_src(1, 1'b1);
    chk_irq(1'b1);
    pulse(4'h0, 1'b1);
    chk_irq(1'b0);
    set_src(2, 1'b1);
    chk_irq(1'b1);
    rd(REG_AN_EXPANSION, v);
    check("reg6", v, 16'hffff);
    chk_irq(1'b0);
    set_src(1, 1'b0);
    set_src(2, 1'b0);
  endtask

  task automatic t_wake();
    wr(REG_WAKE_CTRL, 16'h000e);
    pulse(4'h1, 1'b0);
    chk_irq(1'b0);
    rd(REG_WAKE_CTRL, v);
    check("wake", v, 16'h001e);
    pulse(4'h2, 1'b0);
    chk_irq(1'b1);
    wr(REG_WAKE_CTRL, 16'h002e);
    chk_irq(1'b0);
  endtask

  task automatic t_mask();
    wr(REG_IRQ_MASK, 16'h03fc);
    set_src(1, 1'b1);
    chk_irq(1'b0);
    rd(REG_IRQ_FLAGS, v);
    check("flags", v, 16'h0002);
    rd(REG_IRQ_FLAGS, v);
    check("flags", v, 16'h0000);
    set_src(1, 1'b0);
  endtask

  task automatic t_late();
    int n;
    int m;
    wr(REG_IRQ_MASK, 16'h0080);
    set_src(7, 1'b1);
    chk_irq(1'b1);
    rd(REG_IRQ_FLAGS, v);
    check("flags", v, 16'h0080);
    chk_irq(1'b0);
    @(posedge clk);
    energy <= 1'b0;
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    check("delay", 16'(n >= L_DELAY && n <= L_DELAY + 6), 16'h1);
    m = 0;
    while (irq === 1'b1 && m < 200) begin
      @(posedge clk);
      m++;
    end
    check("pulse", 16'(m + 1 >= L_PULSE && m <= L_PULSE + 1), 16'h1);
    wr(REG_IRQ_MASK, 16'h0000);
  endtask

  task automatic t_alt();
    wr(REG_IRQ_MASK, 16'h03fe);
    wr(REG_MODE_CTRL, 16'h0040);
    rd(REG_MODE_CTRL, v);
    check("mode", v, 16'h0040);
    set_src(6, 1'b1);
    chk_irq(1'b1);
    wr(REG_IRQ_FLAGS, 16'h0040);
    chk_irq(1'b1);
    set_src(6, 1'b0);
    chk_irq(1'b1);
    wr(REG_IRQ_FLAGS, 16'h0040);
    chk_irq(1'b0);
    set_src(4, 1'b1);
    wr(REG_IRQ_FLAGS, 16'h0010);
    chk_irq(1'b1);
    set_src(4, 1'b0);
    wr(REG_IRQ_FLAGS, 16'h0010);
    chk_irq(1'b0);
  endtask

  // Frozen core ignores a source edge until the enable returns
  task automatic t_freeze();
    @(posedge clk);
    clk_en <= 1'b0;
    set_src(9, 1'b1);
    chk_irq(1'b0);
    @(posedge clk);
    clk_en <= 1'b1;
    repeat (3) @(posedge clk);
    chk_irq(1'b1);
    set_src(9, 1'b0);
    chk_irq(1'b0);
  endtask

  // Hard reset in mid-run drops the alternate mode
  task automatic t_rerst();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(REG_MODE_CTRL, v);
    check("mode", v, 16'h0000);
    rd(REG_IRQ_FLAGS, v);
    check("flags", v, 16'h0000);
  endtask

  initial begin
    {rst_n, link_up, an, rf, lp, pd, page, restart} = 8'h00;
    energy = 1'b1;
    clk_en = 1'b1;
    lstat = 1'b1;
    wake_hit = 4'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    t_reset();
    t_primary();
    t_restart();
    t_wake();
    t_mask();
    t_freeze();
    t_late();
    t_alt();
    t_rerst();
    final_report();
  end
endmodule
